/* hdl/rsv_pkg.sv */
package rsv_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] OFF_SYS   = 8'h07;
  localparam logic [7:0] OFF_EN    = 8'h10;
  localparam logic [7:0] OFF_STAT  = 8'h11;
  localparam logic [7:0] OFF_VCC   = 8'h20;
  localparam logic [7:0] OFF_B1TA  = 8'h23;
  // reset values and writable masks
  localparam logic [7:0] SYS_RST   = 8'h28;
  localparam logic [7:0] SYS_WMASK = 8'h70;
  localparam logic [7:0] EN_RST    = 8'h75;
  localparam logic [7:0] EN_WMASK  = 8'h55;
  localparam logic [7:0] STAT_RST  = 8'h00;
  localparam logic [7:0] VCC_RST   = 8'h00;
  localparam logic [7:0] VCC_WMASK = 8'h33;
  localparam logic [7:0] B1TA_WMASK = 8'h1f;
  localparam logic [4:0] B1TA_FIELD_RST = 5'h05;
  // field positions
  localparam int DLY_LSB   = 4;
  localparam int B1_RAMP   = 0;
  localparam int B1_PICK   = 1;
  localparam int B2_RAMP   = 4;
  localparam int B2_PICK   = 5;
  localparam int ST_B1     = 0;
  localparam int ST_B2     = 2;
  localparam int ST_L1     = 4;
  localparam int ST_L2     = 5;
  localparam int ST_LALL   = 6;
  localparam int ST_BALL   = 7;
  // target code limits
  localparam logic [4:0] B1_CODE_MAX = 5'h19;
  localparam logic [4:0] B1_CODE_EXT = 5'h00;
  // serial address
  localparam logic [6:0] BUS_ADDR  = 7'h60;
  // timing: sequencing runs in half-millisecond steps
  localparam int CLK_NS    = 50;
  localparam int STEP_NS   = 500000;
  localparam int STEP_CYC  = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] SEQ_LAST_STEP = 5'h16;

  typedef enum {ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_ACK, ST_RDATA, ST_MACK} rsv_bus_st_t;

  // ==========================================================
  // turn-on delay in steps; idx 0 buck1, 1 buck2, 2 ldo1, 3 ldo2
  function automatic logic [4:0] delay_steps(input logic [2:0] code, input int idx);
    logic [19:0] row;
    row = 20'h00000;
    unique case (code)
      3'h0: row = {5'h02, 5'h02, 5'h02, 5'h02};
      3'h1: row = {5'h04, 5'h04, 5'h03, 5'h02};
      3'h2: row = {5'h0c, 5'h06, 5'h04, 5'h03};
      3'h3: row = {5'h02, 5'h02, 5'h04, 5'h03};
      3'h4: row = {5'h0c, 5'h06, 5'h04, 5'h03};
      3'h5: row = {5'h04, 5'h04, 5'h03, 5'h03};
      3'h6: row = {5'h03, 5'h02, 5'h04, 5'h06};
      3'h7: row = {5'h16, 5'h0c, 5'h06, 5'h04};
    endcase
    return row[idx*5 +: 5];
  endfunction

  // written bits take data, the rest keep their reset value
  function automatic logic [7:0] wmerge(input logic [7:0] rst, input logic [7:0] mask, input logic [7:0] d);
    return (d & mask) | (rst & ~mask);
  endfunction
endpackage

/* hdl/rsv_seq_if.sv */
`timescale 1ns/1ps
interface rsv_seq_if;
  logic       run;
  logic [2:0] code;
  logic [3:0] on;
  modport ctl (output run, output code, input on);
  modport seq (input run, input code, output on);
endinterface

/* hdl/rsv_sequencer.sv */
`timescale 1ns/1ps
module rsv_sequencer #(
  parameter int STEP_CYC = rsv_pkg::STEP_CYC
) (
  input  wire logic clk,
  input  wire logic rstn,
  rsv_seq_if.seq    sif
);
  localparam int PW = $clog2(STEP_CYC + 1);

  if (STEP_CYC < 2) begin : g_chk
    $error("step count must be at least 2");
  end

  logic [PW-1:0] pre;
  logic [PW-1:0] next_pre;
  logic [4:0]    steps;
  logic [4:0]    next_steps;
  logic [3:0]    on;
  wire  [3:0]    next_on;

  // ==========================================================
  // step timer, cleared while the sequence pin is low
  always_comb begin
    next_pre = pre;
    next_steps = steps;
    if (!sif.run) begin
      next_pre = '0;
      next_steps = '0;
    end else if (steps != rsv_pkg::SEQ_LAST_STEP) begin // saturate at the longest delay
      if (pre == PW'(STEP_CYC - 1)) begin
        next_pre = '0;
        next_steps = steps + 5'h01;
      end else begin
        next_pre = pre + PW'(1);
      end
    end
  end

  // each output turns on once its delay has elapsed
  for (genvar i = 0; i < 4; i++) begin : g_out
    assign next_on[i] = sif.run && (steps >= rsv_pkg::delay_steps(sif.code, i));
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pre <= '0;
      steps <= '0;
      on <= 4'h0;
    end else begin
      pre <= next_pre;
      steps <= next_steps;
      on <= next_on;
    end
  end

  assign sif.on = on;

  a_off_idle: assert property (@(posedge clk) disable iff (!rstn) !sif.run |=> on == 4'h0)
    else $error("output on while sequence idle");
  a_steps_sat: assert property (@(posedge clk) disable iff (!rstn) steps <= rsv_pkg::SEQ_LAST_STEP)
    else $error("step count past the longest delay");
  a_on_late: assert property (@(posedge clk) disable iff (!rstn)
    $rose(on[0]) && $stable(sif.code) |-> steps >= rsv_pkg::delay_steps(sif.code, 0))
    else $error("buck1 turned on before its delay");
endmodule

/* hdl/rsv_ctrl.sv */
`timescale 1ns/1ps
module rsv_ctrl #(
  parameter int         STEP_CYC  = rsv_pkg::STEP_CYC,
  parameter logic [6:0] BUS_ADDR  = rsv_pkg::BUS_ADDR,
  parameter logic [4:0] TGT_A_RST = rsv_pkg::B1TA_FIELD_RST
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  input  wire logic       seq_enable_pin,
  input  wire logic [3:0] supply_good,
  output logic      [3:0] supply_on,
  output logic            first_switcher_target_pick,
  output logic            first_switcher_ramp_cmd,
  output logic            second_switcher_target_pick,
  output logic            second_switcher_ramp_cmd,
  output logic      [4:0] first_switcher_level_a,
  output logic            first_switcher_ext_ctrl
);
  rsv_seq_if sif ();

  rsv_sequencer #(.STEP_CYC(STEP_CYC)) u_seq (
    .clk  (clk),
    .rstn (rstn),
    .sif  (sif)
  );

  // ==========================================================
  // pin synchronisers; pins are asynchronous to clk
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic       scl_d;
  logic       sda_d;
  wire        scl_s  = sync2[0];
  wire        sda_s  = sync2[1];
  wire        seq_s  = sync2[2];
  wire  [3:0] good_s = sync2[6:3];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1 <= 7'h03;
      sync2 <= 7'h03;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      sync1 <= {supply_good, seq_enable_pin, sda_in, scl_in};
      sync2 <= sync1;
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

  // ==========================================================
  // register file state
  logic [7:0] sys;
  logic [7:0] en;
  logic [7:0] stat;
  logic [7:0] vcc;
  logic [7:0] b1ta;
  logic [7:0] next_sys;
  logic [7:0] next_en;
  logic [7:0] next_stat;
  logic [7:0] next_vcc;
  logic [7:0] next_b1ta;
  logic [7:0] rd_data;

  // serial slave state
  rsv_pkg::rsv_bus_st_t st;
  rsv_pkg::rsv_bus_st_t next_st;
  rsv_pkg::rsv_bus_st_t after;
  rsv_pkg::rsv_bus_st_t next_after;
  logic [3:0] bitc;
  logic [3:0] next_bitc;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic       drive;
  logic       next_drive;
  logic       wr;
  logic       next_wr;

  // ==========================================================
  // serial slave: bits sampled on scl rise, sda changed on scl fall
  always_comb begin
    next_st = st;
    next_after = after;
    next_bitc = bitc;
    next_shreg = shreg;
    next_ptr = ptr;
    next_drive = drive;
    next_wr = 1'b0;
    if (bus_start) begin // a repeated start is handled like the first one
      next_st = rsv_pkg::ST_ADDR;
      next_bitc = 4'h0;
      next_drive = 1'b0;
    end else if (bus_stop) begin
      next_st = rsv_pkg::ST_IDLE;
      next_drive = 1'b0;
    end else if (st == rsv_pkg::ST_ADDR || st == rsv_pkg::ST_REG || st == rsv_pkg::ST_WDATA) begin
      if (scl_rise && bitc != 4'h8) begin
        next_shreg = {shreg[6:0], sda_s};
        next_bitc = bitc + 4'h1;
      end else if (scl_fall && bitc == 4'h8) begin
        next_st = rsv_pkg::ST_ACK;
        next_drive = 1'b1;
        if (st == rsv_pkg::ST_ADDR) begin
          next_after = shreg[0] ? rsv_pkg::ST_RDATA : rsv_pkg::ST_REG;
          if (shreg[7:1] != BUS_ADDR) begin // not ours: stay off the bus
            next_st = rsv_pkg::ST_IDLE;
            next_drive = 1'b0;
          end
        end else if (st == rsv_pkg::ST_REG) begin
          next_ptr = shreg;
          next_after = rsv_pkg::ST_WDATA;
        end else begin
          next_wr = 1'b1;
          next_after = rsv_pkg::ST_WDATA;
        end
      end
    end else if (st == rsv_pkg::ST_ACK) begin
      if (scl_fall) begin
        next_st = after;
        next_bitc = 4'h0;
        next_drive = 1'b0;
        if (after == rsv_pkg::ST_RDATA) begin
          next_shreg = rd_data;
          next_drive = ~rd_data[7];
        end
      end
    end else if (st == rsv_pkg::ST_RDATA) begin
      if (scl_fall && bitc == 4'h7) begin
        next_st = rsv_pkg::ST_MACK;
        next_drive = 1'b0;
      end else if (scl_fall) begin
        next_shreg = {shreg[6:0], 1'b0};
        next_drive = ~shreg[6];
        next_bitc = bitc + 4'h1;
      end
    end else if (st == rsv_pkg::ST_MACK) begin
      if (scl_rise && sda_s) begin // no acknowledge ends the read
        next_st = rsv_pkg::ST_IDLE;
      end else if (scl_fall) begin
        next_st = rsv_pkg::ST_RDATA;
        next_shreg = rd_data;
        next_drive = ~rd_data[7];
        next_bitc = 4'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= rsv_pkg::ST_IDLE;
      after <= rsv_pkg::ST_IDLE;
      bitc <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      drive <= 1'b0;
      wr <= 1'b0;
    end else begin
      st <= next_st;
      after <= next_after;
      bitc <= next_bitc;
      shreg <= next_shreg;
      ptr <= next_ptr;
      drive <= next_drive;
      wr <= next_wr;
    end
  end

  assign sda_out  = 1'b0; // open drain: only ever pulls low
  assign sda_oe_n = ~drive;

  // ==========================================================
  // read mux; unmapped addresses read 00
  always_comb begin
    rd_data = 8'h00;
    unique case (ptr)
      rsv_pkg::OFF_SYS:  rd_data = sys;
      rsv_pkg::OFF_EN:   rd_data = en;
      rsv_pkg::OFF_STAT: rd_data = stat;
      rsv_pkg::OFF_VCC:  rd_data = vcc;
      rsv_pkg::OFF_B1TA: rd_data = b1ta;
      default:           rd_data = 8'h00;
    endcase
  end

  // register writes; the status register has no write path
  always_comb begin
    next_sys = sys;
    next_en = en;
    next_vcc = vcc;
    next_b1ta = b1ta;
    if (wr) begin
      unique case (ptr)
        rsv_pkg::OFF_SYS:  next_sys = rsv_pkg::wmerge(rsv_pkg::SYS_RST, rsv_pkg::SYS_WMASK, shreg);
        rsv_pkg::OFF_EN:   next_en = rsv_pkg::wmerge(rsv_pkg::EN_RST, rsv_pkg::EN_WMASK, shreg);
        rsv_pkg::OFF_VCC:  next_vcc = rsv_pkg::wmerge(rsv_pkg::VCC_RST, rsv_pkg::VCC_WMASK, shreg);
        rsv_pkg::OFF_B1TA: next_b1ta = shreg & rsv_pkg::B1TA_WMASK;
        default: ;
      endcase
    end
    next_stat = 8'h00;
    next_stat[rsv_pkg::ST_B1]   = good_s[0];
    next_stat[rsv_pkg::ST_B2]   = good_s[1];
    next_stat[rsv_pkg::ST_L1]   = good_s[2];
    next_stat[rsv_pkg::ST_L2]   = good_s[3];
    next_stat[rsv_pkg::ST_BALL] = good_s[0] & good_s[1];
    next_stat[rsv_pkg::ST_LALL] = good_s[2] & good_s[3];
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sys <= rsv_pkg::SYS_RST;
      en <= rsv_pkg::EN_RST;
      stat <= rsv_pkg::STAT_RST;
      vcc <= rsv_pkg::VCC_RST;
      b1ta <= {3'h0, TGT_A_RST};
    end else begin
      sys <= next_sys;
      en <= next_en;
      stat <= next_stat;
      vcc <= next_vcc;
      b1ta <= next_b1ta;
    end
  end

  // ==========================================================
  // outputs; enables gate the sequencer, so software can switch any rail off
  assign sif.run  = seq_s;
  assign sif.code = sys[rsv_pkg::DLY_LSB +: 3];

  logic [3:0] next_on;
  logic [4:0] next_lvl;
  always_comb begin
    next_on = sif.on & {en[6], en[4], en[2], en[0]};
    next_lvl = (b1ta[4:0] > rsv_pkg::B1_CODE_MAX) ? rsv_pkg::B1_CODE_MAX : b1ta[4:0];
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      supply_on <= 4'h0;
      first_switcher_level_a <= 5'h00;
      first_switcher_ext_ctrl <= 1'b0;
    end else begin
      supply_on <= next_on;
      first_switcher_level_a <= next_lvl;
      first_switcher_ext_ctrl <= (b1ta[4:0] == rsv_pkg::B1_CODE_EXT);
    end
  end

  assign first_switcher_ramp_cmd     = vcc[rsv_pkg::B1_RAMP];
  assign first_switcher_target_pick  = vcc[rsv_pkg::B1_PICK];
  assign second_switcher_ramp_cmd    = vcc[rsv_pkg::B2_RAMP];
  assign second_switcher_target_pick = vcc[rsv_pkg::B2_PICK];

  // ==========================================================
  // checks
  sequence s_addr_byte;
    st == rsv_pkg::ST_ADDR && scl_fall && bitc == 4'h8 && shreg[7:1] == BUS_ADDR && !bus_start && !bus_stop;
  endsequence
  sequence s_ack_low;
    !sda_oe_n && st == rsv_pkg::ST_ACK;
  endsequence

  a_addr_ack: assert property (@(posedge clk) disable iff (!rstn) s_addr_byte |=> s_ack_low)
    else $error("matching address not acknowledged");
  a_bucks_both: assert property (@(posedge clk) disable iff (!rstn) stat[7] == (stat[0] & stat[2]))
    else $error("both-bucks bit wrong");
  a_lins_both: assert property (@(posedge clk) disable iff (!rstn) stat[6] == (stat[4] & stat[5]))
    else $error("both-linear bit wrong");
  a_stat_follow: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) |-> stat[5] == $past(good_s[3]) && stat[4] == $past(good_s[2]) && stat[3:1] == {1'b0, $past(good_s[1]), 1'b0})
    else $error("status does not track valid inputs");
  a_en_reset: assert property (@(posedge clk) $rose(rstn) |-> en == 8'h75 && vcc == 8'h00)
    else $error("enable or change register reset wrong");
  a_dly_reset: assert property (@(posedge clk) $rose(rstn) |-> sys[6:4] == 3'h2 && b1ta[7:5] == 3'h0)
    else $error("delay code reset wrong");
  a_vcc_write: assert property (@(posedge clk) disable iff (!rstn)
    wr && ptr == rsv_pkg::OFF_VCC |=> vcc == ($past(shreg) & 8'h33))
    else $error("change register write lost");
  a_lvl_clamp: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) && $past(b1ta[4:0]) >= 5'h1a |-> first_switcher_level_a == 5'h19)
    else $error("target code not clamped");
  a_rail_gate: assert property (@(posedge clk) disable iff (!rstn)
    !en[0] ##1 !en[0] |-> !supply_on[0])
    else $error("buck1 on while disabled");
endmodule

/* verif/rsv_host_model.sv */
`timescale 1ns/1ps
// ==========================================================
// host side of the serial register bus; it only ever pulls sda low
module rsv_host_model (
  input  wire logic clk,
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda_line
);
  localparam int HALF = 6; // well above the 3 clk minimum phase
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic half();
    repeat (HALF) @(posedge clk);
  endtask
  // sda moves one clk after scl falls, so no false start or stop is seen
  task automatic put_bit(input logic b, output logic got);
    @(posedge clk);
    sda_m <= b;
    half();
    scl <= 1'b1;
    half();
    got = sda_line;
    scl <= 1'b0;
  endtask
  // also serves as repeated start after an ack bit
  task automatic start();
    @(posedge clk);
    sda_m <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_m <= 1'b0;
    half();
    scl <= 1'b0;
  endtask
  task automatic stop();
    @(posedge clk);
    sda_m <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_m <= 1'b1;
    half();
  endtask
  // eight bits msb first, ninth bit driven as given; ack means ninth seen low
  task automatic xfer(input logic [7:0] d, input logic ninth, output logic [7:0] q, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], g);
      q[i] = g;
    end
    put_bit(ninth, g);
    ack = ~g;
  endtask
  // chip address with direction 0, register, one data byte; gives up if the address is not acked
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] rg, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    logic       a2;
    a1 = 1'b0;
    a2 = 1'b0;
    start();
    xfer({dev, 1'b0}, 1'b1, q, a0);
    if (a0) begin
      xfer(rg, 1'b1, q, a1);
      xfer(d, 1'b1, q, a2);
    end
    stop();
    ok = a0 & a1 & a2;
  endtask
  // pointer write, repeated start, one byte read and ended by a nack
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] rg, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       nk;
    start();
    xfer({dev, 1'b0}, 1'b1, q, a0);
    xfer(rg, 1'b1, q, a1);
    start();
    xfer({dev, 1'b1}, 1'b1, q, a2);
    xfer(8'hff, 1'b1, d, nk);
    stop();
    ok = a0 & a1 & a2;
  endtask
  // as above, but the first byte is acked so a second one follows before the nack
  task automatic read_pair(input logic [6:0] dev, input logic [7:0] rg, output logic [7:0] d0,
                           output logic [7:0] d1, output logic ok);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       nk;
    start();
    xfer({dev, 1'b0}, 1'b1, q, a0);
    xfer(rg, 1'b1, q, a1);
    start();
    xfer({dev, 1'b1}, 1'b1, q, a2);
    xfer(8'hff, 1'b0, d0, nk);
    xfer(8'hff, 1'b1, d1, nk);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // short step keeps the 11 ms sequence to a few hundred cycles
  localparam int         STEP = 16;
  localparam logic [6:0] DEV  = rsv_pkg::BUS_ADDR;
  localparam logic [7:0] RG [5] = '{8'h07, 8'h10, 8'h11, 8'h20, 8'h23};
  localparam logic [7:0] E0 [5] = '{8'h28, 8'h75, 8'h00, 8'h00, 8'h05};
  localparam logic [7:0] E1 [5] = '{8'h78, 8'h75, 8'h00, 8'h33, 8'h1f};
  localparam logic [7:0] E2 [5] = '{8'h08, 8'h20, 8'h00, 8'h00, 8'h00};
  localparam int DLY [32] = '{2, 2, 2, 2, 2, 3, 4, 4, 3, 4, 6, 12, 3, 4, 2, 2,
                              3, 4, 6, 12, 3, 3, 4, 4, 6, 4, 2, 3, 4, 6, 12, 22};
  localparam logic [7:0] TC [6] = '{8'h00, 8'h01, 8'h0c, 8'h19, 8'h1a, 8'h1f};
  localparam logic [4:0] TL [6] = '{5'h00, 5'h01, 5'h0c, 5'h19, 5'h19, 5'h19};
  // valid-input patterns and the status byte each must read back as
  localparam logic [3:0] SG [6] = '{4'h3, 4'h6, 4'h9, 4'hc, 4'hf, 4'h5};
  localparam logic [7:0] SE [6] = '{8'h85, 8'h14, 8'h21, 8'h70, 8'hf5, 8'h11};
  logic       clk;
  logic       rstn;
  logic       seq_enable_pin;
  logic [3:0] supply_good;
  logic [3:0] supply_on;
  logic       pick1;
  logic       ramp1;
  logic       pick2;
  logic       ramp2;
  logic       ext;
  logic [4:0] level;
  logic       scl;
  logic       sda_m;
  logic       sda_line;
  logic       sda_out;
  logic       sda_oe_n;
  int         n_fail = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  int         ton [4];
  // open-drain wire with pull-up: low if either side pulls
  assign sda_line = sda_m & (sda_oe_n | sda_out);
  rsv_ctrl #(.STEP_CYC(STEP)) u_rsv_ctrl (
    .clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .seq_enable_pin(seq_enable_pin), .supply_good(supply_good), .supply_on(supply_on),
    .first_switcher_target_pick(pick1), .first_switcher_ramp_cmd(ramp1),
    .second_switcher_target_pick(pick2), .second_switcher_ramp_cmd(ramp2),
    .first_switcher_level_a(level), .first_switcher_ext_ctrl(ext));
  rsv_host_model u_rsv_host_model (.clk(clk), .scl(scl), .sda_m(sda_m), .sda_line(sda_line));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ==========================================================
  // compare, report and bus helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi, input string what);
    samples_checked++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s at %0d outside %0d..%0d", $time, what, got, lo, hi);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] rg, input logic [7:0] d);
    logic ok;
    u_rsv_host_model.write_reg(DEV, rg, d, ok);
    chk(ok, 1'b1, "write ack");
  endtask
  task automatic rd(input logic [7:0] rg, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_rsv_host_model.read_reg(DEV, rg, d, ok);
    chk(ok, 1'b1, "read ack");
    chk(d, exp, "read data");
  endtask
  // hang guard: a clean run takes some 30k cycles, so reaching 80k means a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      n_fail++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      report_and_stop();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    logic       ok;
    logic [7:0] rb0;
    logic [7:0] rb1;
    rstn = 1'b0;
    seq_enable_pin = 1'b0;
    supply_good = 4'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 5; i++) rd(RG[i], E0[i]);
    for (int i = 0; i < 5; i++) begin
      wr(RG[i], 8'hff);
      rd(RG[i], E1[i]);
      wr(RG[i], 8'h00);
      rd(RG[i], E2[i]);
    end
    wr(8'h30, 8'h5a);
    rd(8'h30, 8'h00);
    u_rsv_host_model.write_reg(DEV ^ 7'h01, 8'h10, 8'h00, ok);
    chk(ok, 1'b0, "foreign address acked");
    // master ack on the first byte reads the same register again
    u_rsv_host_model.read_pair(DEV, 8'h10, rb0, rb1, ok);
    chk(ok, 1'b1, "pair ack");
    chk({rb0, rb1}, 16'h2020, "pair data");
    // target field decode, including the clamp and external hand-over
    for (int i = 0; i < 6; i++) begin
      wr(8'h23, TC[i]);
      @(negedge clk);
      chk(level, TL[i], "target level");
      chk(ext, TC[i] == 8'h00, "external control");
    end
    wr(8'h20, 8'h12);
    @(negedge clk);
    chk({pick2, ramp2, pick1, ramp1}, 4'h6, "pick and ramp");
    wr(8'h20, 8'h21);
    @(negedge clk);
    chk({pick2, ramp2, pick1, ramp1}, 4'h9, "pick and ramp");
    // status mirrors the valid inputs and their pairwise summaries
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      supply_good <= SG[i];
      repeat (6) @(posedge clk);
      rd(8'h11, SE[i]);
    end
    // turn-on delays for every code, measured from the pin edge
    wr(8'h10, 8'h55);
    for (int c = 0; c < 8; c++) begin
      wr(8'h07, 8'(c << 4));
      seq_enable_pin <= 1'b1;
      ton = '{-1, -1, -1, -1};
      for (int t = 1; t <= 400; t++) begin
        @(negedge clk);
        for (int k = 0; k < 4; k++) if (supply_on[k] === 1'b1 && ton[k] < 0) ton[k] = t;
      end
      for (int k = 0; k < 4; k++) chk_rng(ton[k], DLY[c*4+k]*STEP, DLY[c*4+k]*STEP + 10, "turn-on");
      if (c == 7) begin
        wr(8'h10, 8'h50);
        @(negedge clk);
        chk(supply_on, 4'hc, "buck enables off");
      end
      @(posedge clk);
      seq_enable_pin <= 1'b0;
      repeat (10) @(posedge clk);
    end
    report_and_stop();
  end
endmodule
